/* rtl/bis_pkg.sv */
// Purpose: shared constants and types for the burner input supervisor
// Assumes: mclk at 25 MHz, contact inputs already synchronous
// Notes: long counts are also module parameters so simulation can shorten them
package bis_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SAMPLE_MS = 150;
    localparam int unsigned SAMPLE_CYC = SAMPLE_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_MIN_MS = 1000;
    localparam int unsigned RST_MAX_MS = 3000;
    localparam int unsigned RST_MIN_CYC = RST_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_MAX_CYC = RST_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned RUN_LIMIT_H = 24;
    localparam longint unsigned RUN_LIMIT_CYC = longint'(RUN_LIMIT_H) * 3600 * CLK_HZ;
    localparam int unsigned STEP_CYC = 16;
    localparam logic [7:0] LOC_NONE = 8'h00;
    localparam logic [7:0] LOC_WELD = 8'h0A;
    localparam logic [7:0] LOC_LOOP = 8'h16;
    localparam logic [7:0] LOC_CFG = 8'h3C;
    localparam logic [7:0] LOC_ANA = 8'h3D;
    localparam logic [1:0] COMB_STEP = 2'h0;
    localparam logic [1:0] COMB_NOFUNC = 2'h1;
    localparam logic [2:0] ANA_420_LOCK = 3'h4;

    typedef enum logic [4:0] {
        ST_STANDBY = 5'b0_0001,
        ST_STARTUP = 5'b0_0010,
        ST_OPERATE = 5'b0_0100,
        ST_SHUTDOWN = 5'b0_1000,
        ST_LOCKOUT = 5'b1_0000
    } bis_state_t;

    typedef struct packed {
        logic heatReq;
        logic loadClosed;
        logic loadOpen;
    } bis_contacts_t;

    typedef struct packed {
        logic intermitEn;
        logic purgeHigh;
        logic actuatorOn;
        logic [1:0] combMode;
        logic [2:0] analogSel;
    } bis_cfg_t;

    typedef struct packed {
        logic fuelValve;
        logic fan;
        logic ignition;
        logic loopSupply;
        logic alarm;
        logic driveLow;
        logic driveHigh;
    } bis_outs_t;
endpackage

/* rtl/bis_vote_filter.sv */
// Purpose: 2-out-of-3 majority filter for contact inputs, one sample per tick
// Assumes: tick is a one-cycle pulse every sampling period
// Notes: accepted level changes only when two of the newest three samples agree
`timescale 1ns/1ps
module bis_vote_filter #(
    parameter int W = 3
) (
    input wire logic mclk, // clock
    input wire logic rst_b, // sync reset, active low
    input wire logic tick, // sample strobe
    input wire logic [W-1:0] raw, // unfiltered contacts
    output logic [W-1:0] filt // accepted levels
);
    typedef struct packed {
        logic [W-1:0] s0;
        logic [W-1:0] s1;
        logic [W-1:0] f;
    } bis_vf_state_t;
    bis_vf_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (tick) begin
            st_d.s1 = st_q.s0;
            st_d.s0 = raw;
            // majority of newest three samples
            st_d.f = (raw & st_q.s0) | (raw & st_q.s1) | (st_q.s0 & st_q.s1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign filt = st_q.f;
endmodule

/* rtl/bis_supervisor.sv */
// Purpose: burner contact supervision, actuator steering, safety loop and lockout
// Assumes: inputs synchronous to mclk; safetyLoopOk high while loop closed
// Notes: flame supervision and the full program sequence live elsewhere
`timescale 1ns/1ps
// Function
// - load and heat contacts accepted when two of the newest three samples agree
// - accepted heat request starts the burner startup
// - heat request gone: run shutdown then rest in standby
// - load contacts only obeyed in operating phase
// - load closed drives actuator toward low fire
// - load open drives actuator toward high fire
// - no load input, no drive, actuator holds position
// - open safety loop cuts fuel valve, fan, ignition at the next clock edge
// - open loop during heat request locks out with code 22
// - loop supply only with heat request, off in lockout
// - alarm output on while locked out
// - welded relay lockout code 10 keeps alarm off
// - reset press held over 1 s and under 3 s clears lockout, except welded relay code 10
// - setting enables controlled shutdown after 24 hours running
// - prepurge setting picks low-fire or high-fire actuator position
// - combustion control setting 1 forces lockout
// - 4-20 mA below 4 mA in operating phase locks out only with locking choice
module bis_supervisor #(
    parameter int unsigned SAMPLE_CYC = bis_pkg::SAMPLE_CYC,
    parameter int unsigned RST_MIN_CYC = bis_pkg::RST_MIN_CYC,
    parameter int unsigned RST_MAX_CYC = bis_pkg::RST_MAX_CYC,
    parameter longint unsigned RUN_LIMIT_CYC = bis_pkg::RUN_LIMIT_CYC,
    parameter int unsigned STARTUP_CYC = 64, // stand-in for purge and ignition
    parameter int unsigned SHUTDOWN_CYC = 64 // stand-in for postpurge
) (
    input wire logic mclk, // 25 MHz clock
    input wire logic rst_b, // sync reset, active low
    input wire bis_pkg::bis_contacts_t contacts, // raw heat and load contacts
    input wire logic safetyLoopOk, // safety loop closed
    input wire logic resetBtn, // remote lockout reset button
    input wire logic relayWeldFault, // welded output relay detected
    input wire logic analogLow, // analog current under 4 mA
    input wire bis_pkg::bis_cfg_t cfg, // configuration settings
    output bis_pkg::bis_outs_t outs, // registered output drives
    output bis_pkg::bis_state_t phase, // current phase
    output logic [7:0] lockCode // recorded lockout code
);
    localparam int unsigned LCW = 42; // 24 h of 25 MHz cycles needs 41 bits

    typedef struct packed {
        bis_pkg::bis_state_t st;
        logic [31:0] tickCnt;
        logic tick;
        logic [31:0] seqCnt;
        logic [LCW-1:0] runCnt;
        logic [31:0] pressCnt;
        logic btnPrev;
        logic [7:0] code;
        bis_pkg::bis_outs_t o;
    } bis_sup_state_t;

    bis_sup_state_t s_q, s_d;
    bis_pkg::bis_contacts_t filt;

    bis_vote_filter #(.W(3)) u_filter (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(s_q.tick),
        .raw(contacts),
        .filt(filt)
    );

    function automatic logic pressValid(input logic [31:0] n);
        pressValid = (n > RST_MIN_CYC[31:0]) && (n < RST_MAX_CYC[31:0]);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.btnPrev = resetBtn;
        // sampling strobe
        s_d.tick = 1'b0;
        if (s_q.tickCnt >= SAMPLE_CYC[31:0] - 32'h0000_0001) begin
            s_d.tickCnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tickCnt = s_q.tickCnt + 32'h0000_0001;
        end
        // count reset press length, saturating just past the maximum
        if (resetBtn) begin
            if (s_q.pressCnt <= RST_MAX_CYC[31:0]) begin
                s_d.pressCnt = s_q.pressCnt + 32'h0000_0001;
            end
        end else begin
            s_d.pressCnt = '0;
        end
        if (s_q.seqCnt != '0) begin
            s_d.seqCnt = s_q.seqCnt - 32'h0000_0001;
        end

        case (s_q.st)
            bis_pkg::ST_STANDBY: begin
                s_d.runCnt = '0;
                if (filt.heatReq) begin
                    s_d.st = bis_pkg::ST_STARTUP;
                    s_d.seqCnt = STARTUP_CYC[31:0];
                end
            end
            bis_pkg::ST_STARTUP: begin
                if (!filt.heatReq) begin
                    s_d.st = bis_pkg::ST_SHUTDOWN;
                    s_d.seqCnt = SHUTDOWN_CYC[31:0];
                end else if (s_q.seqCnt == '0) begin
                    s_d.st = bis_pkg::ST_OPERATE;
                end
            end
            bis_pkg::ST_OPERATE: begin
                // saturate so a long run never wraps back under the limit
                if (s_q.runCnt < RUN_LIMIT_CYC[LCW-1:0]) begin
                    s_d.runCnt = s_q.runCnt + {{(LCW-1){1'b0}}, 1'b1};
                end
                // controlled intermittent shutdown after continuous run
                if (!filt.heatReq || (cfg.intermitEn &&
                    s_q.runCnt >= RUN_LIMIT_CYC[LCW-1:0])) begin
                    s_d.st = bis_pkg::ST_SHUTDOWN;
                    s_d.seqCnt = SHUTDOWN_CYC[31:0];
                end
            end
            bis_pkg::ST_SHUTDOWN: begin
                if (s_q.seqCnt == '0) begin
                    s_d.st = bis_pkg::ST_STANDBY;
                end
            end
            bis_pkg::ST_LOCKOUT: begin
                // release on button let go after a valid hold; welded relay stays
                if (!resetBtn && s_q.btnPrev && pressValid(s_q.pressCnt) &&
                    s_q.code != bis_pkg::LOC_WELD && !relayWeldFault &&
                    cfg.combMode != bis_pkg::COMB_NOFUNC) begin
                    s_d.st = bis_pkg::ST_STANDBY;
                    s_d.code = bis_pkg::LOC_NONE;
                end
            end
            default: begin
                s_d.st = bis_pkg::ST_LOCKOUT;
            end
        endcase

        // lockout causes, weld and bad setting take priority over loop
        if (s_q.st != bis_pkg::ST_LOCKOUT) begin
            if (relayWeldFault) begin
                s_d.st = bis_pkg::ST_LOCKOUT;
                s_d.code = bis_pkg::LOC_WELD;
            end else if (cfg.combMode == bis_pkg::COMB_NOFUNC) begin
                s_d.st = bis_pkg::ST_LOCKOUT;
                s_d.code = bis_pkg::LOC_CFG;
            end else if (filt.heatReq && !safetyLoopOk) begin
                s_d.st = bis_pkg::ST_LOCKOUT;
                s_d.code = bis_pkg::LOC_LOOP;
            end else if (analogLow && cfg.analogSel == bis_pkg::ANA_420_LOCK &&
                         s_q.st == bis_pkg::ST_OPERATE) begin
                s_d.st = bis_pkg::ST_LOCKOUT;
                s_d.code = bis_pkg::LOC_ANA;
            end
        end

        // output drives from the next phase
        s_d.o = '0;
        s_d.o.loopSupply = filt.heatReq && s_d.st != bis_pkg::ST_LOCKOUT;
        s_d.o.alarm = s_d.st == bis_pkg::ST_LOCKOUT && s_d.code != bis_pkg::LOC_WELD;
        if (safetyLoopOk) begin
            s_d.o.fan = s_d.st == bis_pkg::ST_STARTUP || s_d.st == bis_pkg::ST_OPERATE ||
                        s_d.st == bis_pkg::ST_SHUTDOWN;
            s_d.o.fuelValve = s_d.st == bis_pkg::ST_OPERATE;
            // next count: standby leaves the old one at zero, which would light early
            s_d.o.ignition = s_d.st == bis_pkg::ST_STARTUP &&
                             s_d.seqCnt < (STARTUP_CYC[31:0] >> 1);
        end
        if (s_d.st == bis_pkg::ST_OPERATE && cfg.actuatorOn) begin
            s_d.o.driveLow = filt.loadClosed && !filt.loadOpen;
            s_d.o.driveHigh = filt.loadOpen && !filt.loadClosed;
        end else if (s_d.st == bis_pkg::ST_STARTUP && cfg.actuatorOn) begin
            // prepurge position
            s_d.o.driveHigh = cfg.purgeHigh;
            s_d.o.driveLow = !cfg.purgeHigh;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_q <= '{st: bis_pkg::ST_STANDBY, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign outs = s_q.o;
    assign phase = s_q.st;
    assign lockCode = s_q.code;

    property p_loop_cut;
        @(posedge mclk) disable iff (!rst_b)
        !safetyLoopOk |=> !outs.fuelValve && !outs.fan && !outs.ignition;
    endproperty
    a_loop_cut: assert property (p_loop_cut) else $error("loop open but power on");

    property p_loop_lock;
        @(posedge mclk) disable iff (!rst_b)
        (filt.heatReq && !safetyLoopOk && s_q.st != bis_pkg::ST_LOCKOUT && !relayWeldFault
         && cfg.combMode != bis_pkg::COMB_NOFUNC)
        |=> phase == bis_pkg::ST_LOCKOUT && lockCode == bis_pkg::LOC_LOOP;
    endproperty
    a_loop_lock: assert property (p_loop_lock) else $error("no loop lockout code 22");

    property p_alarm;
        @(posedge mclk) disable iff (!rst_b)
        outs.alarm == (phase == bis_pkg::ST_LOCKOUT && lockCode != bis_pkg::LOC_WELD);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm mismatch");

    property p_weld_quiet;
        @(posedge mclk) disable iff (!rst_b)
        relayWeldFault && phase != bis_pkg::ST_LOCKOUT |=> !outs.alarm [*2];
    endproperty
    a_weld_quiet: assert property (p_weld_quiet) else $error("alarm on weld lockout");

    property p_supply_off;
        @(posedge mclk) disable iff (!rst_b)
        outs.loopSupply |-> phase != bis_pkg::ST_LOCKOUT;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("loop supply in lockout");

    property p_drive_excl;
        @(posedge mclk) disable iff (!rst_b)
        !(outs.driveLow && outs.driveHigh);
    endproperty
    a_drive_excl: assert property (p_drive_excl) else $error("both drives on");

    property p_drive_gate;
        @(posedge mclk) disable iff (!rst_b)
        (phase != bis_pkg::ST_OPERATE && phase != bis_pkg::ST_STARTUP) |->
        !outs.driveLow && !outs.driveHigh;
    endproperty
    a_drive_gate: assert property (p_drive_gate) else $error("drive outside phase");

    property p_drive_low;
        @(posedge mclk) disable iff (!rst_b)
        $past(s_d.st) == bis_pkg::ST_OPERATE && phase == bis_pkg::ST_OPERATE &&
        $past(filt.loadClosed) && !$past(filt.loadOpen) && $past(cfg.actuatorOn)
        |-> outs.driveLow;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("no low-fire drive");

    sequence s_start;
        phase == bis_pkg::ST_STANDBY ##0 filt.heatReq && !relayWeldFault && safetyLoopOk
        && cfg.combMode != bis_pkg::COMB_NOFUNC;
    endsequence
    property p_start;
        @(posedge mclk) disable iff (!rst_b)
        s_start |=> phase == bis_pkg::ST_STARTUP;
    endproperty
    a_start: assert property (p_start) else $error("startup not begun");

    property p_cfg_lock;
        @(posedge mclk) disable iff (!rst_b)
        cfg.combMode == bis_pkg::COMB_NOFUNC [*2] |-> phase == bis_pkg::ST_LOCKOUT;
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("bad setting not locked");

    property p_drive_high;
        @(posedge mclk) disable iff (!rst_b)
        $past(s_d.st) == bis_pkg::ST_OPERATE && phase == bis_pkg::ST_OPERATE &&
        $past(filt.loadOpen) && !$past(filt.loadClosed) && $past(cfg.actuatorOn)
        |-> outs.driveHigh;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("no high-fire drive");

    property p_drive_idle;
        @(posedge mclk) disable iff (!rst_b)
        phase == bis_pkg::ST_OPERATE && $past(filt.loadOpen) == $past(filt.loadClosed)
        |-> !outs.driveLow && !outs.driveHigh;
    endproperty
    a_drive_idle: assert property (p_drive_idle) else $error("idle drive on");

    // demand gone in operation, no lockout cause pending
    sequence s_run_end;
        phase == bis_pkg::ST_OPERATE ##0 !filt.heatReq && !relayWeldFault &&
        cfg.combMode != bis_pkg::COMB_NOFUNC &&
        !(analogLow && cfg.analogSel == bis_pkg::ANA_420_LOCK);
    endsequence
    property p_stop;
        @(posedge mclk) disable iff (!rst_b)
        s_run_end |=> phase == bis_pkg::ST_SHUTDOWN;
    endproperty
    a_stop: assert property (p_stop) else $error("no shutdown on lost demand");

    sequence s_shut_done;
        phase == bis_pkg::ST_SHUTDOWN ##0 s_q.seqCnt == '0 && !relayWeldFault &&
        cfg.combMode != bis_pkg::COMB_NOFUNC && !(filt.heatReq && !safetyLoopOk);
    endsequence
    property p_rest;
        @(posedge mclk) disable iff (!rst_b)
        s_shut_done |=> phase == bis_pkg::ST_STANDBY;
    endproperty
    a_rest: assert property (p_rest) else $error("no standby after shutdown");

    property p_supply_req;
        @(posedge mclk) disable iff (!rst_b)
        outs.loopSupply |-> $past(filt.heatReq);
    endproperty
    a_supply_req: assert property (p_supply_req) else $error("supply without demand");

    property p_press_bad;
        @(posedge mclk) disable iff (!rst_b)
        phase == bis_pkg::ST_LOCKOUT && !resetBtn && s_q.btnPrev &&
        (s_q.pressCnt <= RST_MIN_CYC[31:0] || s_q.pressCnt >= RST_MAX_CYC[31:0])
        |=> phase == bis_pkg::ST_LOCKOUT;
    endproperty
    a_press_bad: assert property (p_press_bad) else $error("bad press released");

    property p_ignite_phase;
        @(posedge mclk) disable iff (!rst_b)
        outs.ignition |-> phase == bis_pkg::ST_STARTUP && $past(safetyLoopOk);
    endproperty
    a_ignite_phase: assert property (p_ignite_phase) else $error("stray ignition");

    property p_purge;
        @(posedge mclk) disable iff (!rst_b)
        phase == bis_pkg::ST_STARTUP |->
        outs.driveHigh == $past(cfg.purgeHigh && cfg.actuatorOn);
    endproperty
    a_purge: assert property (p_purge) else $error("prepurge position wrong");
endmodule

/* test/bis_contact_model.sv */
// Purpose: thermostat, load controller and safety loop contacts
// Assumes: bench commands each level at a rising edge of mclk
// Notes: bounce-free contacts; the bench holds load and heat levels for three samples, bar one short heat pulse
`timescale 1ns/1ps
module bis_contact_model (
    input wire logic mclk, // clock
    input wire bis_pkg::bis_contacts_t want, // levels asked by bench
    input wire logic loopWant, // loop closed asked by bench
    output bis_pkg::bis_contacts_t contacts, // contacts to device
    output logic safetyLoopOk // loop state to device
);
    // one cycle of contact travel, so the device never sees bench edges directly
    always_ff @(posedge mclk) begin
        contacts <= want;
        safetyLoopOk <= loopWant;
    end
endmodule

/* test/bis_supervisor_tb.sv */
// Purpose: self-checking bench for the burner input supervisor
// Assumes: shortened counts, sample tick every 4 cycles
// Notes: contacts reach the device through the contact model
`timescale 1ns/1ps
module bis_supervisor_tb;
    localparam int SMP = 4;
    localparam int FLT = 3 * SMP + 4;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    bis_pkg::bis_contacts_t want = 3'h0;
    logic loopWant = 1'h1;
    logic resetBtn = 1'h0;
    logic relayWeldFault = 1'h0;
    logic analogLow = 1'h0;
    bis_pkg::bis_cfg_t cfg = 8'h20;
    bis_pkg::bis_contacts_t contacts;
    logic safetyLoopOk;
    bis_pkg::bis_outs_t o;
    bis_pkg::bis_state_t phase;
    logic [7:0] lockCode;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    always #20 mclk = ~mclk;

    bis_contact_model partner (.mclk(mclk), .want(want), .loopWant(loopWant),
        .contacts(contacts), .safetyLoopOk(safetyLoopOk));
    bis_supervisor #(.SAMPLE_CYC(SMP), .RST_MIN_CYC(10), .RST_MAX_CYC(30),
        .RUN_LIMIT_CYC(200), .STARTUP_CYC(16), .SHUTDOWN_CYC(16)) dut (
        .mclk(mclk), .rst_b(rst_b), .contacts(contacts), .safetyLoopOk(safetyLoopOk),
        .resetBtn(resetBtn), .relayWeldFault(relayWeldFault), .analogLow(analogLow),
        .cfg(cfg), .outs(o), .phase(phase), .lockCode(lockCode));

    task automatic results();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, well above the under one thousand cycles the sequence needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chkB(input string nm, input logic e, input logic g);
        #1;
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkV(input string nm, input logic [7:0] e, input logic [7:0] g);
        #1;
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkPh(input bis_pkg::bis_state_t e);
        #1;
        n_tests++;
        if (phase !== e) begin
            fails++;
            $display("ERROR phase expected %h seen %h", e, phase);
        end
    endtask

    // bounded wait; a miss is reported by the final compare
    task automatic waitPh(input bis_pkg::bis_state_t e, input int lim);
        repeat (lim) begin
            #1;
            if (phase === e)
                break;
            @(posedge mclk);
        end
        chkPh(e);
    endtask

    task automatic rstPulse();
        tick(1);
        rst_b <= 1'h0;
        tick(3);
        rst_b <= 1'h1;
        tick(1);
    endtask

    task automatic press(input int n);
        tick(1);
        resetBtn <= 1'h1;
        tick(n);
        resetBtn <= 1'h0;
        tick(3);
    endtask

    task automatic load(input logic c, input logic op, input logic l, input logic h);
        tick(1);
        want.loadClosed <= c;
        want.loadOpen <= op;
        tick(FLT);
        chkB("driveLow", l, o.driveLow);
        chkB("driveHigh", h, o.driveHigh);
    endtask

    task automatic toOperate();
        tick(1);
        want.heatReq <= 1'h1;
        waitPh(bis_pkg::ST_STARTUP, FLT);
        chkB("driveHigh", cfg.purgeHigh, o.driveHigh);
        waitPh(bis_pkg::ST_OPERATE, 40);
    endtask

    task automatic lockChk(input logic [7:0] c, input logic a);
        chkPh(bis_pkg::ST_LOCKOUT);
        chkV("lockCode", c, lockCode);
        chkB("alarm", a, o.alarm);
    endtask

    initial begin
        tick(3);
        rst_b <= 1'h1;
        chkPh(bis_pkg::ST_STANDBY);
        chkV("outs", 8'h00, {1'h0, o});
        chkV("lockCode", 8'h00, lockCode);
        // a pulse shorter than one period can win at most one sample
        tick(1);
        want.heatReq <= 1'h1;
        tick(3);
        want.heatReq <= 1'h0;
        tick(FLT);
        chkPh(bis_pkg::ST_STANDBY);
        load(1'h0, 1'h1, 1'h0, 1'h0);
        tick(1);
        want.heatReq <= 1'h1;
        waitPh(bis_pkg::ST_STARTUP, FLT);
        chkB("fan", 1'h1, o.fan);
        chkB("loopSupply", 1'h1, o.loopSupply);
        chkB("driveHigh", 1'h0, o.driveHigh);
        chkB("driveLow", 1'h1, o.driveLow);
        chkB("ignition", 1'h0, o.ignition);
        tick(12);
        chkB("ignition", 1'h1, o.ignition);
        waitPh(bis_pkg::ST_OPERATE, 40);
        chkB("fuelValve", 1'h1, o.fuelValve);
        load(1'h0, 1'h1, 1'h0, 1'h1);
        load(1'h1, 1'h0, 1'h1, 1'h0);
        load(1'h1, 1'h1, 1'h0, 1'h0);
        load(1'h0, 1'h0, 1'h0, 1'h0);
        tick(1);
        cfg.actuatorOn <= 1'h0;
        load(1'h0, 1'h1, 1'h0, 1'h0);
        tick(1);
        cfg.actuatorOn <= 1'h1;
        want.loadOpen <= 1'h0;
        tick(1);
        want.heatReq <= 1'h0;
        waitPh(bis_pkg::ST_SHUTDOWN, FLT);
        chkB("fuelValve", 1'h0, o.fuelValve);
        waitPh(bis_pkg::ST_STANDBY, 30);
        tick(1);
        cfg.intermitEn <= 1'h1;
        cfg.purgeHigh <= 1'h1;
        toOperate();
        tick(150);
        chkPh(bis_pkg::ST_OPERATE);
        waitPh(bis_pkg::ST_SHUTDOWN, 80);
        tick(1);
        want.heatReq <= 1'h0;
        cfg.intermitEn <= 1'h0;
        waitPh(bis_pkg::ST_STANDBY, 80);
        toOperate();
        tick(1);
        loopWant <= 1'h0;
        tick(3);
        chkB("fuelValve", 1'h0, o.fuelValve);
        chkB("fan", 1'h0, o.fan);
        chkB("ignition", 1'h0, o.ignition);
        lockChk(8'h16, 1'h1);
        chkB("loopSupply", 1'h0, o.loopSupply);
        tick(1);
        loopWant <= 1'h1;
        want.heatReq <= 1'h0;
        tick(FLT);
        press(5);
        chkPh(bis_pkg::ST_LOCKOUT);
        press(40);
        chkPh(bis_pkg::ST_LOCKOUT);
        press(20);
        chkPh(bis_pkg::ST_STANDBY);
        chkV("lockCode", 8'h00, lockCode);
        tick(1);
        relayWeldFault <= 1'h1;
        tick(4);
        lockChk(8'h0A, 1'h0);
        tick(1);
        relayWeldFault <= 1'h0;
        press(20);
        chkPh(bis_pkg::ST_LOCKOUT);
        rstPulse();
        chkPh(bis_pkg::ST_STANDBY);
        tick(1);
        cfg.combMode <= bis_pkg::COMB_NOFUNC;
        tick(4);
        lockChk(bis_pkg::LOC_CFG, 1'h1);
        tick(1);
        cfg.combMode <= bis_pkg::COMB_STEP;
        rstPulse();
        tick(1);
        cfg.analogSel <= 3'h5;
        analogLow <= 1'h1;
        toOperate();
        tick(210);
        chkPh(bis_pkg::ST_OPERATE);
        tick(1);
        cfg.analogSel <= bis_pkg::ANA_420_LOCK;
        tick(4);
        lockChk(bis_pkg::LOC_ANA, 1'h1);
        results();
    end
endmodule
